//--- verilog/dcpc_clock_ctrl.sv
// Overview of operation
// [R1] After reset all clocks and the clock receiver stay powered down.
// [R2] Writing zero to clock power control powers up every clock domain.
// [R3] Power bits: 7 converter0, 6 converter1, 5 digital, 4 serializer, 3 receiver.
// [R4] Sample clock comes from the PLL or directly from the input clock.
// [R5] Software programs all PLL settings before enabling the PLL.
// [R6] Software picks reference ratio so the detector input is 35 to 80 MHz.
// [R7] Reference code 0..4 decodes to divide by 1, 2, 4, 8, 16.
// [R8] Feedback count is an 8-bit field; software uses only 6 to 127.
// [R9] Software sets sample clock over twice the count equal to divided reference.
// [R10] Output code 1, 2, 3 decodes to divide by 4, 8, 16.
// [R11] Software keeps the oscillator between 6 and 12 GHz.
// [R12] Oscillator frequency is sample clock times the output divide ratio.
// [R13] Software assumes reference 35 MHz..1 GHz, output 420 MHz..2.8 GHz.
// [R14] Software loads recommended filter, pump and regulator settings.
// [R15] Software loads recommended oscillator, calibration, varactor, lock-length settings.
// [R16] Loop filter has five 4-bit component settings over three registers.
// [R17] Bit 4 of PLL control enables the synthesizer.
// [R18] Bit 1 of PLL status reports lock.
// [R19] On band-edge flag, software clears then sets PLL control bit 7 to recalibrate.
// [R20] Enabled synthesizer drives the sample clock, else the receiver output does.
`include "dcpc_params.svh"
`default_nettype none
module dcpc_clock_ctrl
    import dcpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port from the serial interface engine
    input wire dcpc_req_t regReq,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Status from the analog PLL, asynchronous
    input wire logic pllLockedAsync,
    input wire logic bandUpperAsync,
    input wire logic bandLowerAsync,
    input wire logic pumpCalDoneAsync,
    // Clock domain enables and source
    output dcpc_clk_en_t clockEnable,
    output dcpc_src_t sampleClockSource,
    // PLL controls
    output logic pllEnable,
    output logic pllRecalibrate,
    output logic [5:0] referenceDivideRatio,
    output logic [4:0] outputDivideRatio,
    output logic [7:0] loopDivideCount,
    output logic loopCountLegal,
    output dcpc_filter_t loopFilter,
    output logic [7:0] pumpCurrentSetting,
    output logic [7:0] pllRegulatorSetting
);

    dcpc_state_t q, d;

    function automatic logic [5:0] decodeRefRatio(input logic [2:0] code);
        case (code)
            3'h0: decodeRefRatio = 6'h01; // R7
            3'h1: decodeRefRatio = 6'h02; // R7
            3'h2: decodeRefRatio = 6'h04; // R7
            3'h3: decodeRefRatio = 6'h08; // R7
            3'h4: decodeRefRatio = 6'h10; // R7
            3'h5: decodeRefRatio = 6'h20;
            // Unlisted codes fall back to no division
            default: decodeRefRatio = 6'h01;
        endcase
    endfunction

    function automatic logic [4:0] decodeOutRatio(input logic [1:0] code);
        case (code)
            2'h1: decodeOutRatio = 5'h04; // R10
            2'h2: decodeOutRatio = 5'h08; // R10
            2'h3: decodeOutRatio = 5'h10; // R10
            // Code 0 is not a legal mode; treated like the fastest range
            default: decodeOutRatio = 5'h04;
        endcase
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    logic [7:0] statusByte;
    logic wr;

    always_comb begin
        d = q;
        wr = regReq.wrEn;
        // Lock is only meaningful while the synthesizer runs
        statusByte = 8'h00;
        statusByte[`DCPC_BIT_ST_UPPER] = q.statusSync2[2];
        statusByte[`DCPC_BIT_ST_LOWER] = q.statusSync2[1];
        statusByte[`DCPC_BIT_ST_CALDONE] = q.statusSync2[3];
        statusByte[`DCPC_BIT_ST_LOCK] = q.statusSync2[0] & q.pllEnable; // R18

        d.statusSync1 = {pumpCalDoneAsync, bandUpperAsync, bandLowerAsync, pllLockedAsync};
        d.statusSync2 = q.statusSync1;

        if (wr) begin
            if (hit(regReq.addr, `DCPC_ADDR_CLK_POWER)) begin
                d.clkPower = {regReq.wrData[7:3], 3'h0}; // R2
            end
            if (hit(regReq.addr, `DCPC_ADDR_PLL_CONTROL)) begin
                d.pllControl = regReq.wrData; // R17
            end
            if (hit(regReq.addr, `DCPC_ADDR_LOOP_COUNT)) begin
                d.loopCount = regReq.wrData; // R8
            end
            if (hit(regReq.addr, `DCPC_ADDR_FILTER_A)) begin
                d.filterA = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_FILTER_B)) begin
                d.filterB = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_FILTER_C)) begin
                d.filterC = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_PUMP_CURRENT)) begin
                d.pumpCurrent = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_OUT_DIV)) begin
                d.outDiv = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_REF_DIV)) begin
                d.refDiv = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_REGULATOR)) begin
                d.regulator = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_POWER_MACHINE)) begin
                d.powerMachine = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_PUMP_AUX)) begin
                d.pumpAux = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_VCO_CONTROL)) begin
                d.vcoControl = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_VCO_POWER)) begin
                d.vcoPower = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_VCO_CAL)) begin
                d.vcoCal = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_LOCK_LENGTH)) begin
                d.lockLength = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_PUMP_TRIM)) begin
                d.pumpTrim = regReq.wrData;
            end
            if (hit(regReq.addr, `DCPC_ADDR_VARACTOR)) begin
                d.varactor = regReq.wrData;
            end
        end

        // Read answer one cycle after the request; unmapped reads give zero
        d.rdValid = regReq.rdEn & ~wr;
        d.rdData = 8'h00;
        if (regReq.rdEn & ~wr) begin
            case (regReq.addr)
                `DCPC_ADDR_CLK_POWER: d.rdData = q.clkPower;
                `DCPC_ADDR_PLL_CONTROL: d.rdData = q.pllControl;
                `DCPC_ADDR_PLL_STATUS: d.rdData = statusByte;
                `DCPC_ADDR_LOOP_COUNT: d.rdData = q.loopCount;
                `DCPC_ADDR_FILTER_A: d.rdData = q.filterA;
                `DCPC_ADDR_FILTER_B: d.rdData = q.filterB;
                `DCPC_ADDR_FILTER_C: d.rdData = q.filterC;
                `DCPC_ADDR_PUMP_CURRENT: d.rdData = q.pumpCurrent;
                `DCPC_ADDR_OUT_DIV: d.rdData = q.outDiv;
                `DCPC_ADDR_REF_DIV: d.rdData = q.refDiv;
                `DCPC_ADDR_REGULATOR: d.rdData = q.regulator;
                `DCPC_ADDR_POWER_MACHINE: d.rdData = q.powerMachine;
                `DCPC_ADDR_PUMP_AUX: d.rdData = q.pumpAux;
                `DCPC_ADDR_VCO_CONTROL: d.rdData = q.vcoControl;
                `DCPC_ADDR_VCO_POWER: d.rdData = q.vcoPower;
                `DCPC_ADDR_VCO_CAL: d.rdData = q.vcoCal;
                `DCPC_ADDR_LOCK_LENGTH: d.rdData = q.lockLength;
                `DCPC_ADDR_PUMP_TRIM: d.rdData = q.pumpTrim;
                `DCPC_ADDR_VARACTOR: d.rdData = q.varactor;
                default: d.rdData = 8'h00;
            endcase
        end

        // Power bits are active high power-down
        d.clkEn.conv0 = ~q.clkPower[`DCPC_BIT_PD_CONV0]; // R3
        d.clkEn.conv1 = ~q.clkPower[`DCPC_BIT_PD_CONV1]; // R3
        d.clkEn.digital = ~q.clkPower[`DCPC_BIT_PD_DIGITAL]; // R3
        d.clkEn.serial = ~q.clkPower[`DCPC_BIT_PD_SERIAL]; // R3
        d.clkEn.receiver = ~q.clkPower[`DCPC_BIT_PD_RECEIVER]; // R3

        d.pllEnable = q.pllControl[`DCPC_BIT_PLL_ENABLE]; // R17
        d.source = q.pllControl[`DCPC_BIT_PLL_ENABLE] ? DCPC_SRC_PLL : DCPC_SRC_BYPASS; // R4 R20
        // Recalibration fires on the 0 to 1 edge of the control bit
        d.recalPulse = wr & hit(regReq.addr, `DCPC_ADDR_PLL_CONTROL)
            & regReq.wrData[`DCPC_BIT_PLL_RECAL]
            & ~q.pllControl[`DCPC_BIT_PLL_RECAL]; // R19

        d.refRatio = decodeRefRatio(q.refDiv[2:0]); // R7
        d.outRatio = decodeOutRatio(q.outDiv[1:0]); // R10 R12
        d.countLegal = (q.loopCount >= `DCPC_LOOP_COUNT_MIN)
            && (q.loopCount <= `DCPC_LOOP_COUNT_MAX); // R8

        d.filter.c1 = q.filterA[7:4]; // R16
        d.filter.c2 = q.filterA[3:0]; // R16
        d.filter.c3 = q.filterB[7:4]; // R16
        d.filter.r1 = q.filterB[3:0]; // R16
        d.filter.r3 = q.filterC[3:0]; // R16
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            q <= '0;
            q.clkPower <= `DCPC_RST_CLK_POWER; // R1
            q.pllControl <= `DCPC_RST_OTHER;
            q.refRatio <= 6'h01;
            q.outRatio <= 5'h04;
        end else begin
            q <= d;
        end
    end

    assign regRdData = q.rdData;
    assign regRdValid = q.rdValid;
    assign clockEnable = q.clkEn;
    assign sampleClockSource = q.source;
    assign pllEnable = q.pllEnable;
    assign pllRecalibrate = q.recalPulse;
    assign referenceDivideRatio = q.refRatio;
    assign outputDivideRatio = q.outRatio;
    assign loopDivideCount = q.loopCount;
    assign loopCountLegal = q.countLegal;
    assign loopFilter = q.filter;
    assign pumpCurrentSetting = q.pumpCurrent;
    assign pllRegulatorSetting = q.regulator;

endmodule
`default_nettype wire

//--- verilog/dcpc_params.svh
`ifndef DCPC_PARAMS_SVH
`define DCPC_PARAMS_SVH

// Register offsets
`define DCPC_ADDR_CLK_POWER 12'h080
`define DCPC_ADDR_PLL_CONTROL 12'h083
`define DCPC_ADDR_PLL_STATUS 12'h084
`define DCPC_ADDR_LOOP_COUNT 12'h085
`define DCPC_ADDR_FILTER_A 12'h087
`define DCPC_ADDR_FILTER_B 12'h088
`define DCPC_ADDR_FILTER_C 12'h089
`define DCPC_ADDR_PUMP_CURRENT 12'h08A
`define DCPC_ADDR_OUT_DIV 12'h08B
`define DCPC_ADDR_REF_DIV 12'h08C
`define DCPC_ADDR_REGULATOR 12'h08D
`define DCPC_ADDR_POWER_MACHINE 12'h1B0
`define DCPC_ADDR_PUMP_AUX 12'h1B9
`define DCPC_ADDR_VCO_CONTROL 12'h1BC
`define DCPC_ADDR_VCO_POWER 12'h1BE
`define DCPC_ADDR_VCO_CAL 12'h1BF
`define DCPC_ADDR_LOCK_LENGTH 12'h1C0
`define DCPC_ADDR_PUMP_TRIM 12'h1C1
`define DCPC_ADDR_VARACTOR 12'h1C4

// Clock power control bit positions (1 = powered down)
`define DCPC_BIT_PD_CONV0 7
`define DCPC_BIT_PD_CONV1 6
`define DCPC_BIT_PD_DIGITAL 5
`define DCPC_BIT_PD_SERIAL 4
`define DCPC_BIT_PD_RECEIVER 3

// PLL control and status bit positions
`define DCPC_BIT_PLL_ENABLE 4
`define DCPC_BIT_PLL_RECAL 7
`define DCPC_BIT_ST_UPPER 7
`define DCPC_BIT_ST_LOWER 6
`define DCPC_BIT_ST_CALDONE 5
`define DCPC_BIT_ST_LOCK 1

// Reset values
`define DCPC_RST_CLK_POWER 8'hF8
`define DCPC_RST_OTHER 8'h00

// Feedback count legal range
`define DCPC_LOOP_COUNT_MIN 8'h06
`define DCPC_LOOP_COUNT_MAX 8'h7F

`endif

//--- verilog/dcpc_pkg.sv
`default_nettype none
package dcpc_pkg;

    typedef struct packed {
        logic [11:0] addr;
        logic wrEn;
        logic rdEn;
        logic [7:0] wrData;
    } dcpc_req_t;

    typedef struct packed {
        logic conv0;
        logic conv1;
        logic digital;
        logic serial;
        logic receiver;
    } dcpc_clk_en_t;

    typedef struct packed {
        logic [3:0] c1;
        logic [3:0] c2;
        logic [3:0] c3;
        logic [3:0] r1;
        logic [3:0] r3;
    } dcpc_filter_t;

    typedef enum logic {
        DCPC_SRC_BYPASS,
        DCPC_SRC_PLL
    } dcpc_src_t;

    typedef struct packed {
        logic [7:0] clkPower;
        logic [7:0] pllControl;
        logic [7:0] loopCount;
        logic [7:0] filterA;
        logic [7:0] filterB;
        logic [7:0] filterC;
        logic [7:0] pumpCurrent;
        logic [7:0] outDiv;
        logic [7:0] refDiv;
        logic [7:0] regulator;
        logic [7:0] powerMachine;
        logic [7:0] pumpAux;
        logic [7:0] vcoControl;
        logic [7:0] vcoPower;
        logic [7:0] vcoCal;
        logic [7:0] lockLength;
        logic [7:0] pumpTrim;
        logic [7:0] varactor;
        logic [3:0] statusSync1;
        logic [3:0] statusSync2;
        logic [7:0] rdData;
        logic rdValid;
        dcpc_clk_en_t clkEn;
        dcpc_src_t source;
        logic pllEnable;
        logic recalPulse;
        logic [5:0] refRatio;
        logic [4:0] outRatio;
        logic countLegal;
        dcpc_filter_t filter;
    } dcpc_state_t;

endpackage
`default_nettype wire

//--- sim/dcpc_clock_ctrl_chk.sv
`default_nettype none
module dcpc_clock_ctrl_chk
    import dcpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire dcpc_req_t regReq,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // Clock and PLL controls
    input wire dcpc_clk_en_t clockEnable,
    input wire dcpc_src_t sampleClockSource,
    input wire logic pllEnable,
    input wire logic pllRecalibrate,
    input wire logic [5:0] referenceDivideRatio,
    input wire logic [4:0] outputDivideRatio,
    input wire logic [7:0] loopDivideCount,
    input wire logic loopCountLegal,
    input wire dcpc_filter_t loopFilter
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [15:0] dataPipe_q;
    logic [7:0] dOld;
    logic rdReq;
    logic wrPower;
    logic wrControl;
    logic wrCount;
    logic wrFilter;
    logic wrOutDiv;
    logic wrRefDiv;
    logic wrRecal;
    // Data of the write two edges back, where its outputs land
    always_ff @(posedge clock) begin
        dataPipe_q <= {dataPipe_q[7:0], regReq.wrData};
    end
    assign dOld = dataPipe_q[15:8];
    assign rdReq = regReq.rdEn && !regReq.wrEn;
    assign wrPower = regReq.wrEn && regReq.addr == 12'h080;
    assign wrControl = regReq.wrEn && regReq.addr == 12'h083;
    assign wrCount = regReq.wrEn && regReq.addr == 12'h085;
    assign wrFilter = regReq.wrEn && regReq.addr == 12'h087;
    assign wrOutDiv = regReq.wrEn && regReq.addr == 12'h08B;
    assign wrRefDiv = regReq.wrEn && regReq.addr == 12'h08C;
    assign wrRecal = wrControl && regReq.wrData[7];

    a_down_at_reset: assert property ($rose(resetn) |-> clockEnable == 5'h00
        && sampleClockSource == DCPC_SRC_BYPASS && !pllEnable) else $error("not down at reset");
    a_power_bit_map: assert property (wrPower |-> ##2 clockEnable == ~dOld[7:3])
        else $error("clock enables wrong");
    // Back to back reads are legal, so the second cycle follows the next request
    a_read_answer: assert property (rdReq |=> regRdValid ##1 regRdValid == $past(rdReq))
        else $error("read answer wrong");
    a_no_stray_read: assert property (!rdReq |=> !regRdValid && regRdData == 8'h00)
        else $error("stray read data");
    a_enable_follows: assert property (wrControl |-> ##2 pllEnable == dOld[4])
        else $error("pll enable wrong");
    a_source_select: assert property (wrControl |-> ##2 sampleClockSource ==
        (dOld[4] ? DCPC_SRC_PLL : DCPC_SRC_BYPASS)) else $error("clock source wrong");
    a_ref_decode: assert property (wrRefDiv |-> ##2 referenceDivideRatio ==
        (dOld[2:0] > 3'h5 ? 6'h01 : 6'h01 << dOld[2:0])) else $error("ref ratio wrong");
    a_out_decode: assert property (wrOutDiv |-> ##2 outputDivideRatio ==
        (dOld[1:0] == 2'h0 ? 5'h04 : 5'h02 << dOld[1:0])) else $error("out ratio wrong");
    // Count is a direct copy one edge after the write; the flag lags one more
    a_count_legal: assert property (wrCount |=> loopDivideCount == dataPipe_q[7:0] ##1
        loopCountLegal == (dOld >= 8'h06 && dOld <= 8'h7F)) else $error("count flag wrong");
    a_filter_map: assert property (wrFilter |-> ##2 loopFilter.c1 == dOld[7:4]
        && loopFilter.c2 == dOld[3:0]) else $error("filter map wrong");
    a_recal_pulse: assert property (pllRecalibrate |-> !$past(pllRecalibrate)
        && ($past(wrRecal) || $past(wrRecal, 2))) else $error("recal pulse wrong");
endmodule

bind dcpc_clock_ctrl dcpc_clock_ctrl_chk u_chk (.clock(clock), .resetn(resetn),
    .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
    .clockEnable(clockEnable), .sampleClockSource(sampleClockSource),
    .pllEnable(pllEnable), .pllRecalibrate(pllRecalibrate),
    .referenceDivideRatio(referenceDivideRatio), .outputDivideRatio(outputDivideRatio),
    .loopDivideCount(loopDivideCount), .loopCountLegal(loopCountLegal),
    .loopFilter(loopFilter));
`default_nettype wire

//--- sim/test_dac_clock_pll_config.sv
`default_nettype none
module test_dac_clock_pll_config
    import dcpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0] w;
        logic [7:0] r;
    } dcpc_row_t;
    dcpc_row_t rows [21] = '{'{12'h080, 8'h00, 8'h00}, '{12'h080, 8'hFF, 8'hF8},
        '{12'h083, 8'h6F, 8'h6F}, '{12'h084, 8'hFF, 8'h00}, '{12'h085, 8'h7F, 8'h7F},
        '{12'h087, 8'h62, 8'h62}, '{12'h088, 8'hC9, 8'hC9}, '{12'h089, 8'h0E, 8'h0E},
        '{12'h08A, 8'h12, 8'h12}, '{12'h08B, 8'h03, 8'h03}, '{12'h08C, 8'h05, 8'h05},
        '{12'h08D, 8'h7B, 8'h7B}, '{12'h1B0, 8'h00, 8'h00}, '{12'h1B9, 8'h24, 8'h24},
        '{12'h1BC, 8'h0D, 8'h0D}, '{12'h1BE, 8'h02, 8'h02}, '{12'h1BF, 8'h8E, 8'h8E},
        '{12'h1C0, 8'h2A, 8'h2A}, '{12'h1C1, 8'h2A, 8'h2A}, '{12'h1C4, 8'h7E, 8'h7E},
        '{12'h0A0, 8'h55, 8'h00}};
    logic [7:0] counts [4] = '{8'h05, 8'h06, 8'h7F, 8'h80};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    dcpc_req_t regReq = '0;
    logic pllLocked = 1'b0;
    logic bandUpper = 1'b0;
    logic bandLower = 1'b0;
    logic calDone = 1'b0;
    logic [7:0] regRdData;
    logic regRdValid;
    dcpc_clk_en_t clockEnable;
    dcpc_src_t sampleClockSource;
    logic pllEnable;
    logic pllRecalibrate;
    logic [5:0] referenceDivideRatio;
    logic [4:0] outputDivideRatio;
    logic [7:0] loopDivideCount;
    logic loopCountLegal;
    dcpc_filter_t loopFilter;
    logic [7:0] pumpCurrentSetting;
    logic [7:0] pllRegulatorSetting;
    int miscompares = 0;
    int checks = 0;
    int recalCount = 0;

    dcpc_clock_ctrl u_dut (.clock(clock), .resetn(resetn), .regReq(regReq),
        .regRdData(regRdData), .regRdValid(regRdValid), .pllLockedAsync(pllLocked),
        .bandUpperAsync(bandUpper), .bandLowerAsync(bandLower), .pumpCalDoneAsync(calDone),
        .clockEnable(clockEnable), .sampleClockSource(sampleClockSource),
        .pllEnable(pllEnable), .pllRecalibrate(pllRecalibrate),
        .referenceDivideRatio(referenceDivideRatio), .outputDivideRatio(outputDivideRatio),
        .loopDivideCount(loopDivideCount), .loopCountLegal(loopCountLegal),
        .loopFilter(loopFilter), .pumpCurrentSetting(pumpCurrentSetting),
        .pllRegulatorSetting(pllRegulatorSetting));

    always #5 clock = ~clock;
    always @(posedge clock) begin
        if (pllRecalibrate === 1'b1) recalCount++;
    end

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Idle cycle after each access keeps strobes from being re-driven in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        regReq = '{a, 1'b1, 1'b0, d};
        step(1);
        regReq = '0;
        step(1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        regReq = '{a, 1'b0, 1'b1, 8'h00};
        step(1);
        regReq = '0;
        check({regRdValid, regRdData}, {1'b1, e});
        step(1);
    endtask

    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end

    initial begin
        step(3);
        resetn = 1'b1;
        check({clockEnable, sampleClockSource, pllEnable}, 7'h00);
        check({referenceDivideRatio, outputDivideRatio}, {6'h01, 5'h04});
        rd(12'h080, 8'hF8);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        check(loopFilter, 20'h62C9E);
        check({pumpCurrentSetting, pllRegulatorSetting}, 16'h127B);
        for (int c = 0; c < 8; c++) begin
            wr(12'h08C, 8'(c));
            check(referenceDivideRatio, (c > 5) ? 1 : 1 << c);
        end
        for (int c = 0; c < 4; c++) begin
            wr(12'h08B, 8'(c));
            check(outputDivideRatio, (c == 0) ? 4 : 2 << c);
        end
        wr(12'h080, 8'h00);
        check(clockEnable, 5'h1F);
        wr(12'h080, 8'hA8);
        check(clockEnable, 5'h0A);
        wr(12'h080, 8'h50);
        check(clockEnable, 5'h15);
        foreach (counts[i]) begin
            wr(12'h085, counts[i]);
            check({loopDivideCount, loopCountLegal}, {counts[i], 1'(i % 3 != 0)});
        end
        pllLocked = 1'b1;
        bandUpper = 1'b1;
        calDone = 1'b1;
        step(2);
        // Legal setup before enabling: 122.88 MHz reference, 983.04 MHz sample clock
        wr(12'h08C, 8'h01);
        wr(12'h085, 8'h08);
        wr(12'h08B, 8'h02);
        check({referenceDivideRatio, outputDivideRatio}, {6'h02, 5'h08});
        check(loopCountLegal, 1'b1);
        wr(12'h083, 8'h10);
        check({pllEnable, sampleClockSource}, 2'h3);
        rd(12'h084, 8'hA2);
        bandUpper = 1'b0;
        bandLower = 1'b1;
        wr(12'h083, 8'h00);
        step(2);
        check({pllEnable, sampleClockSource}, 2'h0);
        rd(12'h084, 8'h60);
        // No earlier control write set bit 7, so the count starts from zero here
        wr(12'h083, 8'h80);
        wr(12'h083, 8'h80);
        check(recalCount, 1);
        wr(12'h083, 8'h00);
        wr(12'h083, 8'h80);
        check(recalCount, 2);
        resetn = 1'b0;
        step(2);
        resetn = 1'b1;
        check({clockEnable, pllEnable}, 6'h00);
        rd(12'h080, 8'hF8);
        tally_and_finish;
    end
endmodule
`default_nettype wire
